// *** rtl/pilc_pkg.sv ***
// Package with register map, field layout and reset values of the PI loop controller.
package pilc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W = 10;
  localparam int unsigned GAIN_W = 16;
  localparam int unsigned ACC_W  = 24;

  // ==========================================================================
  // Register word addresses on the Avalon-MM bus
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_TARGET    = 4'h1;
  localparam logic [3:0] ADDR_PGAIN     = 4'h2;
  localparam logic [3:0] ADDR_IGAIN     = 4'h3;
  localparam logic [3:0] ADDR_MAXOUT    = 4'h4;
  localparam logic [3:0] ADDR_MINOUT    = 4'h5;
  localparam logic [3:0] ADDR_OFFSET    = 4'h6;
  localparam logic [3:0] ADDR_CFG       = 4'h7;
  localparam logic [3:0] ADDR_FAULTVAL  = 4'h8;
  localparam logic [3:0] ADDR_TRIP      = 4'h9;
  localparam logic [3:0] ADDR_TRIGGER   = 4'ha;
  localparam logic [3:0] ADDR_STATUS    = 4'hb;

  // ==========================================================================
  // Control word values and bit positions
  localparam logic [15:0] CTRL_STOP_VAL  = 16'h0004;
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CFG_POL_BIT    = 0;
  localparam int unsigned CFG_IMP_BIT    = 1;
  localparam int unsigned TRIG_NVM_BIT   = 0;

  // ==========================================================================
  // Reset values
  localparam logic [9:0]  RST_TARGET   = 10'h200;
  localparam logic [15:0] RST_PGAIN    = 16'h0064;
  localparam logic [15:0] RST_IGAIN    = 16'h0000;
  localparam logic [9:0]  RST_MAXOUT   = 10'h3ff;
  localparam logic [9:0]  RST_MINOUT   = 10'h000;
  localparam logic [9:0]  RST_OFFSET   = 10'h0bf;
  localparam logic [9:0]  RST_FAULTVAL = 10'h000;
  localparam logic [9:0]  RST_TRIP     = 10'h200;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned LOOP_PERIOD_US = 10;
  localparam int unsigned LOOP_CYCLES    = LOOP_PERIOD_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PILC_IDLE  = 2'b00,
    PILC_SAMPLE = 2'b01,
    PILC_CALC  = 2'b11,
    PILC_APPLY = 2'b10
  } pilc_state_t;

  typedef struct packed {
    logic [9:0] target;
    logic [9:0] offset;
  } pilc_dyn_t;

  typedef struct packed {
    logic [15:0] pgain;
    logic [15:0] igain;
    logic [9:0]  maxout;
    logic [9:0]  minout;
    logic [9:0]  faultval;
    logic [9:0]  trip;
    logic        polarity;
    logic        imp_sel;
  } pilc_static_t;

endpackage

// *** rtl/pilc_top.sv ***
// PI loop controller: register slave, control sequencer and output clamp.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Summary of operation
// - Measurement comes from sense input zero; result drives output channel one.
// - Channel two compares; a trip forces channel one to the fault value.
// - Error equals 10-bit target minus the sensed sample in input codes.
// - Proportional term is error times the 16-bit proportional gain.
// - Integral term is accumulated error divided by the 16-bit inverse gain.
// - An inverse integral gain of zero disables the integral term.
// - Outside a fault, output never exceeds the programmed 10-bit upper limit.
// - Outside a fault, output never falls below the programmed 10-bit lower limit, unless that limit exceeds the upper limit, which then wins.
// - Nominal offset appears at output when both terms are zero.
// - Polarity bit inverts loop phase when set.
// - 10-bit fault value is the output while the comparator is tripped.
// - Impedance select: 0 gives high impedance, 1 finite impedance.
// - 10-bit trip level sets the fault comparator threshold.
// - Writing the control word with bit 0 set starts the loop sequencer.
// - Setting the store trigger commits parameters to nonvolatile memory.
// - Static parameters are nonvolatile; dynamic target and offset are not.
module pilc_top #(
  parameter int unsigned LOOP_CYCLES_P = pilc_pkg::LOOP_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [9:0]  sense_input_i,
  input  wire logic [9:0]  clamp_comparator_input_i,
  output logic [9:0]       loop_output_pin_o,
  output logic             sense_imp_sel_o,
  output logic             nvm_store_o,
  input  wire logic        nvm_busy_i,
  output pilc_pkg::pilc_static_t nvm_image_o
);

  // ==========================================================================
  // Saturation helper.
  function automatic logic signed [pilc_pkg::ACC_W-1:0] sat_add(
    input logic signed [pilc_pkg::ACC_W-1:0] a,
    input logic signed [pilc_pkg::ACC_W-1:0] b
  );
    logic signed [pilc_pkg::ACC_W:0] s;
    s = {a[pilc_pkg::ACC_W-1], a} + {b[pilc_pkg::ACC_W-1], b};
    if (s[pilc_pkg::ACC_W] != s[pilc_pkg::ACC_W-1]) begin
      sat_add = s[pilc_pkg::ACC_W] ? {1'b1, {(pilc_pkg::ACC_W-1){1'b0}}}
                                   : {1'b0, {(pilc_pkg::ACC_W-1){1'b1}}};
    end else begin
      sat_add = s[pilc_pkg::ACC_W-1:0];
    end
  endfunction

  // ==========================================================================
  // Registers.
  pilc_pkg::pilc_static_t stat_q;
  pilc_pkg::pilc_dyn_t    dyn_q;
  logic                   run_q;
  logic                   ack_q;
  logic                   nvm_store_q;
  logic [31:0]            rdata_q;
  logic                   wr_fire;
  logic                   rd_fire;

  assign wr_fire           = avs_write_i && ack_q;
  assign rd_fire           = avs_read_i && !ack_q;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_readdata_o    = rdata_q;

  // One wait state: a write takes effect at the edge where waitrequest is low.
  // Reads are fetched one cycle earlier so that the data stand at that edge.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_q.pgain    <= pilc_pkg::RST_PGAIN;
      stat_q.igain    <= pilc_pkg::RST_IGAIN;
      stat_q.maxout   <= pilc_pkg::RST_MAXOUT;
      stat_q.minout   <= pilc_pkg::RST_MINOUT;
      stat_q.faultval <= pilc_pkg::RST_FAULTVAL;
      stat_q.trip     <= pilc_pkg::RST_TRIP;
      stat_q.polarity <= 1'b0;
      stat_q.imp_sel  <= 1'b0;
      dyn_q.target    <= pilc_pkg::RST_TARGET;
      dyn_q.offset    <= pilc_pkg::RST_OFFSET;
    end else if (wr_fire) begin
      unique case (avs_address_i)
        pilc_pkg::ADDR_TARGET:   dyn_q.target    <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_PGAIN:    stat_q.pgain    <= avs_writedata_i[15:0];
        pilc_pkg::ADDR_IGAIN:    stat_q.igain    <= avs_writedata_i[15:0];
        pilc_pkg::ADDR_MAXOUT:   stat_q.maxout   <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_MINOUT:   stat_q.minout   <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_OFFSET:   dyn_q.offset    <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_FAULTVAL: stat_q.faultval <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_TRIP:     stat_q.trip     <= avs_writedata_i[9:0];
        pilc_pkg::ADDR_CFG: begin
          stat_q.polarity <= avs_writedata_i[pilc_pkg::CFG_POL_BIT];
          stat_q.imp_sel  <= avs_writedata_i[pilc_pkg::CFG_IMP_BIT];
        end
        default: ;
      endcase
    end
  end

  // Any write of the control word with bit 0 set starts; 0004h stops.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (wr_fire && avs_address_i == pilc_pkg::ADDR_CTRL) begin
      run_q <= avs_writedata_i[pilc_pkg::CTRL_RUN_BIT];
    end
  end

  // Store trigger: one-cycle pulse toward the nonvolatile memory.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nvm_store_q <= 1'b0;
    end else begin
      nvm_store_q <= wr_fire && avs_address_i == pilc_pkg::ADDR_TRIGGER
                     && avs_writedata_i[pilc_pkg::TRIG_NVM_BIT];
    end
  end
  assign nvm_store_o     = nvm_store_q;
  assign nvm_image_o     = stat_q;
  assign sense_imp_sel_o = stat_q.imp_sel;

  // ==========================================================================
  // Loop sequencer.
  pilc_pkg::pilc_state_t state_q;
  logic [31:0]           tick_q;
  logic [9:0]            sample_q;
  logic [9:0]            out_q;
  logic                  fault_q;
  logic signed [pilc_pkg::ACC_W-1:0] acc_q;
  logic signed [10:0]    err;
  logic signed [pilc_pkg::ACC_W-1:0] err_x;
  logic signed [pilc_pkg::ACC_W+16:0] p_term;
  logic signed [pilc_pkg::ACC_W+16:0] i_term;
  logic signed [pilc_pkg::ACC_W+16:0] sum;
  logic signed [pilc_pkg::ACC_W+16:0] signed_sum;
  logic [9:0]            clamped;

  assign err   = $signed({1'b0, dyn_q.target}) - $signed({1'b0, sample_q});
  assign err_x = {{(pilc_pkg::ACC_W-11){err[10]}}, err};

  always_comb begin
    p_term = $signed({{(pilc_pkg::ACC_W+6){err[10]}}, err})
             * $signed({{(pilc_pkg::ACC_W+1){1'b0}}, stat_q.pgain});
    if (stat_q.igain == 16'h0000) begin
      i_term = '0;
    end else begin
      i_term = $signed({{17{acc_q[pilc_pkg::ACC_W-1]}}, acc_q})
               / $signed({{(pilc_pkg::ACC_W+1){1'b0}}, stat_q.igain});
    end
    signed_sum = stat_q.polarity ? -(p_term + i_term) : (p_term + i_term);
    sum = $signed({{(pilc_pkg::ACC_W+7){1'b0}}, dyn_q.offset}) + signed_sum;
    if (sum > $signed({{(pilc_pkg::ACC_W+7){1'b0}}, stat_q.maxout})) begin
      clamped = stat_q.maxout;
    end else if (sum < $signed({{(pilc_pkg::ACC_W+7){1'b0}}, stat_q.minout})) begin
      clamped = (stat_q.minout > stat_q.maxout) ? stat_q.maxout : stat_q.minout;
    end else begin
      clamped = sum[9:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= pilc_pkg::PILC_IDLE;
      tick_q  <= 32'h0;
    end else if (!run_q) begin
      state_q <= pilc_pkg::PILC_IDLE;
      tick_q  <= 32'h0;
    end else begin
      unique case (state_q)
        pilc_pkg::PILC_IDLE: begin
          if (tick_q == 32'h0) begin
            state_q <= pilc_pkg::PILC_SAMPLE;
            tick_q  <= LOOP_CYCLES_P - 32'h1;
          end else begin
            tick_q <= tick_q - 32'h1;
          end
        end
        pilc_pkg::PILC_SAMPLE: state_q <= pilc_pkg::PILC_CALC;
        pilc_pkg::PILC_CALC:   state_q <= pilc_pkg::PILC_APPLY;
        pilc_pkg::PILC_APPLY: begin
          state_q <= pilc_pkg::PILC_IDLE;
          tick_q  <= tick_q - 32'h3;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sample_q <= 10'h000;
    end else if (state_q == pilc_pkg::PILC_SAMPLE) begin
      sample_q <= sense_input_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_q) begin
      acc_q <= '0;
    end else if (state_q == pilc_pkg::PILC_CALC && stat_q.igain != 16'h0000) begin
      acc_q <= sat_add(acc_q, err_x);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= clamp_comparator_input_i > stat_q.trip;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_q <= pilc_pkg::RST_MINOUT;
    end else if (fault_q) begin
      out_q <= stat_q.faultval;
    end else if (state_q == pilc_pkg::PILC_APPLY) begin
      out_q <= clamped;
    end
  end
  assign loop_output_pin_o = out_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else if (rd_fire) begin
      unique case (avs_address_i)
        pilc_pkg::ADDR_CTRL:     rdata_q <= {31'h0, run_q};
        pilc_pkg::ADDR_TARGET:   rdata_q <= {22'h0, dyn_q.target};
        pilc_pkg::ADDR_PGAIN:    rdata_q <= {16'h0, stat_q.pgain};
        pilc_pkg::ADDR_IGAIN:    rdata_q <= {16'h0, stat_q.igain};
        pilc_pkg::ADDR_MAXOUT:   rdata_q <= {22'h0, stat_q.maxout};
        pilc_pkg::ADDR_MINOUT:   rdata_q <= {22'h0, stat_q.minout};
        pilc_pkg::ADDR_OFFSET:   rdata_q <= {22'h0, dyn_q.offset};
        pilc_pkg::ADDR_CFG:      rdata_q <= {30'h0, stat_q.imp_sel, stat_q.polarity};
        pilc_pkg::ADDR_FAULTVAL: rdata_q <= {22'h0, stat_q.faultval};
        pilc_pkg::ADDR_TRIP:     rdata_q <= {22'h0, stat_q.trip};
        pilc_pkg::ADDR_STATUS:   rdata_q <= {20'h0, nvm_busy_i, fault_q, out_q};
        default:                 rdata_q <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Assertions.
  a_out_upper_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == pilc_pkg::PILC_APPLY && !fault_q)
      |=> (loop_output_pin_o <= $past(stat_q.maxout)))
    else $error("output above upper limit");
  a_out_lower_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == pilc_pkg::PILC_APPLY && !fault_q && stat_q.minout <= stat_q.maxout)
      |=> (loop_output_pin_o >= $past(stat_q.minout)))
    else $error("output below lower limit");
  a_fault_clamp_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fault_q |=> (loop_output_pin_o == $past(stat_q.faultval)))
    else $error("fault value not forced");
  a_trip_level_cmp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (clamp_comparator_input_i > stat_q.trip) |=> fault_q)
    else $error("comparator did not trip");
  a_acc_clear_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !run_q |=> (acc_q == '0))
    else $error("accumulator not cleared");
  a_igain_zero_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (stat_q.igain == 16'h0000 && run_q) |=> $stable(acc_q) || !run_q)
    else $error("integral active with zero gain");
  a_start_runs_loop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_fire && !run_q && avs_address_i == pilc_pkg::ADDR_CTRL && avs_writedata_i[0])
      |=> ##1 (state_q == pilc_pkg::PILC_SAMPLE))
    else $error("sequencer did not start");
  a_offset_nominal_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == pilc_pkg::PILC_APPLY && !fault_q && p_term == '0 && i_term == '0
      && dyn_q.offset >= stat_q.minout && dyn_q.offset <= stat_q.maxout)
      |=> (loop_output_pin_o == $past(dyn_q.offset)))
    else $error("nominal offset not at output");
  a_nvm_store_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_fire && avs_address_i == pilc_pkg::ADDR_TRIGGER && avs_writedata_i[0])
      |=> nvm_store_o ##1 !nvm_store_o)
    else $error("store trigger missing");
  a_imp_select_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_fire && avs_address_i == pilc_pkg::ADDR_CFG)
      |=> (sense_imp_sel_o == $past(avs_writedata_i[1])))
    else $error("impedance select wrong");

endmodule

// *** verif/pilc_plant.sv ***
// Far-side model: thermal sensor, fault comparator source and nonvolatile store.
`timescale 1ns/10ps
module pilc_plant (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] sense_level_i,
  input  wire logic [9:0] cmp_level_i,
  input  wire logic       nvm_store_i,
  output logic [9:0]      sense_input_o,
  output logic [9:0]      clamp_comparator_input_o,
  output logic            nvm_busy_o
);
  logic [4:0] busy_cnt_q;
  // ==========================================================================
  // Sensor and comparator source follow the environment one cycle late.
  always_ff @(posedge clk_sys_i) begin
    sense_input_o            <= sense_level_i;
    clamp_comparator_input_o <= cmp_level_i;
  end
  // ==========================================================================
  // A store keeps the memory busy for sixteen cycles.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_cnt_q <= 5'h00;
    end else if (nvm_store_i) begin
      busy_cnt_q <= 5'h10;
    end else if (busy_cnt_q != 5'h00) begin
      busy_cnt_q <= busy_cnt_q - 5'h01;
    end
  end
  assign nvm_busy_o = (busy_cnt_q != 5'h00);
endmodule

// *** verif/pi_loop_controller_10bit_test.sv ***
// Self-checking bench of the PI loop controller against a behavioural loop model.
`timescale 1ns/10ps
module pi_loop_controller_10bit_test;
  localparam int LC = 8;
  logic                   clk_sys_i       = 1'b0;
  logic                   rst_i           = 1'b1;
  logic [3:0]             avs_address_i   = 4'h0;
  logic                   avs_read_i      = 1'b0;
  logic                   avs_write_i     = 1'b0;
  logic [31:0]            avs_writedata_i = 32'h0;
  logic [31:0]            avs_readdata_o;
  logic                   avs_waitrequest_o;
  logic [9:0]             sense_input_i;
  logic [9:0]             clamp_comparator_input_i;
  logic [9:0]             loop_output_pin_o;
  logic                   sense_imp_sel_o;
  logic                   nvm_store_o;
  logic                   nvm_busy_i;
  pilc_pkg::pilc_static_t nvm_image_o;
  logic [9:0]             sense_level = 10'h000;
  logic [9:0]             cmp_level   = 10'h000;
  logic [9:0]             first;
  logic [31:0]            rd;
  logic [31:0]            rv [9];
  int                     bad_count   = 0;
  int                     num_checks  = 0;
  int                     store_cnt   = 0;
  int                     tg;
  int                     sm;
  int                     off;

  pilc_top #(.LOOP_CYCLES_P(LC)) DUT (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sense_input_i,
    .clamp_comparator_input_i, .loop_output_pin_o, .sense_imp_sel_o, .nvm_store_o,
    .nvm_busy_i, .nvm_image_o);
  pilc_plant plant (.clk_sys_i, .rst_i, .sense_level_i(sense_level), .cmp_level_i(cmp_level),
    .nvm_store_i(nvm_store_o), .sense_input_o(sense_input_i),
    .clamp_comparator_input_o(clamp_comparator_input_i), .nvm_busy_o(nvm_busy_i));

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (nvm_store_o === 1'b1) store_cnt++;

  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it one edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    check(32'(n < 50), 32'h1);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  function automatic logic [9:0] model(int t, int s, int kp, int o, int mn, int mx, int p);
    int r;
    r = (t - s) * kp;
    if (p != 0) r = -r;
    r = r + o;
    if (r > mx) r = mx;
    else if (r < mn) r = mn;
    return 10'(r);
  endfunction
  // Stops the loop, programs every parameter, starts it and waits into the second period, before its output is applied.
  task automatic setup(int t, int s, int kp, int ki, int o, int mn, int mx, int p, int im,
                       int fv, int tr);
    logic [31:0] v [9];
    v = '{32'(t), 32'(kp), 32'(ki), 32'(mx), 32'(mn), 32'(o), 32'(im * 2 + p), 32'(fv), 32'(tr)};
    bus(1'b1, pilc_pkg::ADDR_CTRL, {16'h0, pilc_pkg::CTRL_STOP_VAL});
    sense_level <= 10'(s);
    for (int k = 0; k < 9; k++) bus(1'b1, 4'(k + 1), v[k]);
    bus(1'b1, pilc_pkg::ADDR_CTRL, 32'h1);
    repeat (5 + LC / 2) @(posedge clk_sys_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    test_done();
  end

  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(80));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rv = '{32'(pilc_pkg::RST_TARGET), 32'(pilc_pkg::RST_PGAIN), 32'(pilc_pkg::RST_IGAIN),
           32'(pilc_pkg::RST_MAXOUT), 32'(pilc_pkg::RST_MINOUT), 32'(pilc_pkg::RST_OFFSET),
           32'h0, 32'(pilc_pkg::RST_FAULTVAL), 32'(pilc_pkg::RST_TRIP)};
    for (int k = 0; k < 9; k++) begin
      bus(1'b0, 4'(k + 1), 32'h0);
      check(rd, rv[k]);
    end
    bus(1'b1, 4'hc, 32'h3ff);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    check(32'(loop_output_pin_o), 32'h0);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      tg  = 100 + int'($urandom % 800);
      sm  = (i == 0) ? tg : tg + int'($urandom % 41) - 20;
      off = (i == 0) ? 500 : int'($urandom % 1024);
      rv[0] = 32'($urandom % 8);
      rv[1] = 32'($urandom % 300);
      rv[2] = 32'(700 + $urandom % 324);
      setup(tg, sm, rv[0], 0, off, rv[1], rv[2], i % 2, (i / 2) % 2, 0, 1023);
      first = model(tg, sm, rv[0], off, rv[1], rv[2], i % 2);
      check(32'(loop_output_pin_o), 32'(first));
      check(32'(sense_imp_sel_o), 32'((i / 2) % 2));
      bus(1'b0, pilc_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'(first));
    end
    $display("Test proportional loop done");
    for (int ki = 2; ki <= 4; ki += 2) begin
      setup(500, 496, 0, ki, 300, 0, 1023, 0, 0, 0, 1023);
      for (int j = 1; j <= 4; j++) begin
        check(32'(loop_output_pin_o), 32'(300 + j * 4 / ki));
        repeat (LC) @(posedge clk_sys_i);
      end
      setup(500, 496, 0, ki, 300, 0, 1023, 0, 0, 0, 1023);
      check(32'(loop_output_pin_o), 32'(300 + 4 / ki));
    end
    setup(500, 496, 0, 0, 300, 0, 1023, 0, 0, 0, 1023);
    check(32'(loop_output_pin_o), 32'd300);
    $display("Test integral term done");
    setup(500, 500, 0, 0, 400, 0, 1023, 0, 0, 341, 256);
    cmp_level <= 10'h100;
    repeat (5) @(posedge clk_sys_i);
    check(32'(loop_output_pin_o), 32'd400);
    cmp_level <= 10'h101;
    repeat (5) @(posedge clk_sys_i);
    check(32'(loop_output_pin_o), 32'h155);
    bus(1'b0, pilc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h555);
    cmp_level <= 10'h000;
    repeat (LC + 5) @(posedge clk_sys_i);
    check(32'(loop_output_pin_o), 32'd400);
    $display("Test fault clamp done");
    bus(1'b1, pilc_pkg::ADDR_TRIGGER, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    check(32'(store_cnt), 32'h1);
    check({nvm_image_o.faultval, nvm_image_o.trip, nvm_image_o.maxout}, 32'h155403ff);
    bus(1'b0, pilc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h990);
    bus(1'b0, pilc_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    $display("Test nonvolatile store done");
    test_done();
  end
endmodule
